/* shared/rtwd_map.svh */
`ifndef RTWD_MAP_SVH
`define RTWD_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define RTWD_OFS_CONFIG 8'h00
`define RTWD_OFS_COUNT 8'h04
`define RTWD_OFS_WDOG 8'h08
`define RTWD_OFS_INT_STATUS 8'h0C
`define RTWD_OFS_INT_MASK 8'h10

// ****************************************************************
// Configuration register fields
// ****************************************************************
`define RTWD_CFG_SEL_LSB 0
`define RTWD_CFG_SEL_MSB 2
`define RTWD_CFG_ASSIGN_BIT 3
`define RTWD_CFG_EDGE_BIT 4
`define RTWD_CFG_SOURCE_BIT 5
`define RTWD_CFG_RESET 8'hFF

// ****************************************************************
// Watchdog control and interrupt fields
// ****************************************************************
`define RTWD_WDOG_EN_BIT 0
`define RTWD_WDOG_KICK_BIT 1
`define RTWD_WDOG_EN_RESET 1'h0
`define RTWD_INT_WRAP_BIT 0
`define RTWD_INT_TMO_BIT 1
`define RTWD_INT_RESET 2'h0

// ****************************************************************
// Timing counts
// ****************************************************************
`define RTWD_WDOG_TICK_CYCLES 16

`endif

/* shared/rtwd_pkg.sv */
package rtwd_pkg;

  // ****************************************************************
  // Divider state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] cnt;
  } rtwd_div_state_t;

  // ****************************************************************
  // Top-level state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] count;
    logic [7:0] wdog;
    logic wdog_en;
    logic [15:0] wtick;
    logic sync1;
    logic sync2;
    logic sync3;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic irq;
    logic wdog_rst;
  } rtwd_state_t;

  // Low-bit mask for a ratio of 2 to the power sel plus one
  function automatic logic [7:0] div_mask(input logic [2:0] sel);
    logic [8:0] ratio;
    // Shift amount widened so select 7 shifts by eight, not zero
    ratio = 9'h001 << ({1'b0, sel} + 4'h1);
    return ratio[7:0] - 8'h01;
  endfunction

endpackage

/* shared/rtwd_div_if.sv */
interface rtwd_div_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic ce;
  logic clr;
  logic tick_in;
  logic [2:0] sel;
  logic tick_out;

  // Controller side
  modport ctrl (
    output ce,
    output clr,
    output tick_in,
    output sel,
    input tick_out
  );

  // Divider side
  modport div (
    input pclk,
    input presetn,
    input ce,
    input clr,
    input tick_in,
    input sel,
    output tick_out
  );
endinterface

/* hw/rtwd_divider.sv */
module rtwd_divider (
  // Link to controller
  rtwd_div_if.div dv
);

  rtwd_pkg::rtwd_div_state_t st_r;
  rtwd_pkg::rtwd_div_state_t st_nxt;
  logic [7:0] mask;
  logic full;

  // ****************************************************************
  // Ratio decode and output tick
  // ****************************************************************
  assign mask = rtwd_pkg::div_mask(dv.sel);
  assign full = (st_r.cnt & mask) == mask;
  assign dv.tick_out = dv.tick_in & full;

  // Next count, cleared on request
  always_comb
  begin
    st_nxt = st_r;
    if (dv.clr)
    begin
      st_nxt.cnt = 8'h00;
    end
    else if (dv.tick_in)
    begin
      st_nxt.cnt = full ? 8'h00 : st_r.cnt + 8'h01;
    end
  end

  // State register, frozen while enable low
  always_ff @(posedge dv.pclk or negedge dv.presetn)
  begin
    if (!dv.presetn)
    begin
      st_r <= '0;
    end
    else if (dv.ce)
    begin
      st_r <= st_nxt;
    end
  end

endmodule

/* hw/rtwd_top.sv */
// Added by the designer: the register offsets and the APB register port.
`include "rtwd_map.svh"

module rtwd_top #(
  parameter int WDOG_TICK_CYCLES = `RTWD_WDOG_TICK_CYCLES
) (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // External count pin
  input wire logic ext_count_pin,
  // Events
  output logic irq,
  output logic wdog_reset_pulse
);

  localparam logic [15:0] TICK_LAST = 16'(WDOG_TICK_CYCLES - 1);

  rtwd_pkg::rtwd_state_t st_r;
  rtwd_pkg::rtwd_state_t st_nxt;

  rtwd_div_if div_link (
    .pclk(pclk),
    .presetn(presetn)
  );

  // ****************************************************************
  // Shared divider
  // ****************************************************************
  rtwd_divider u_div (
    .dv(div_link.div)
  );

  // ****************************************************************
  // Bus phase decode
  // ****************************************************************
  logic setup_ph;
  logic done;
  logic wr;
  logic rd;
  logic wr_cfg;
  logic wr_count;
  logic wr_wdog;
  logic wr_mask;
  logic rd_status;
  logic kick;

  // Transfer completes on the access cycle with pready high
  assign setup_ph = psel & ~penable;
  assign done = psel & penable & st_r.pready;
  assign wr = done & pwrite;
  assign rd = done & ~pwrite;
  assign wr_cfg = wr & (paddr == `RTWD_OFS_CONFIG);
  assign wr_count = wr & (paddr == `RTWD_OFS_COUNT);
  assign wr_wdog = wr & (paddr == `RTWD_OFS_WDOG);
  assign wr_mask = wr & (paddr == `RTWD_OFS_INT_MASK);
  assign rd_status = rd & (paddr == `RTWD_OFS_INT_STATUS);
  assign kick = wr_wdog & pwdata[`RTWD_WDOG_KICK_BIT];

  // ****************************************************************
  // Configuration fields
  // ****************************************************************
  logic assign_wdog;
  logic src_pin;
  logic edge_fall;
  logic [2:0] sel;

  assign assign_wdog = st_r.cfg[`RTWD_CFG_ASSIGN_BIT];
  assign src_pin = st_r.cfg[`RTWD_CFG_SOURCE_BIT];
  assign edge_fall = st_r.cfg[`RTWD_CFG_EDGE_BIT];
  assign sel = st_r.cfg[`RTWD_CFG_SEL_MSB:`RTWD_CFG_SEL_LSB];

  // ****************************************************************
  // Count source
  // ****************************************************************
  logic pin_rise;
  logic pin_fall;
  logic pin_edge;
  logic src_tick;

  // Edges seen only after the two-flop synchroniser
  assign pin_rise = st_r.sync2 & ~st_r.sync3;
  assign pin_fall = ~st_r.sync2 & st_r.sync3;
  assign pin_edge = edge_fall ? pin_fall : pin_rise;
  assign src_tick = src_pin ? pin_edge : 1'b1;

  // ****************************************************************
  // Watchdog tick and wrap
  // ****************************************************************
  logic wdog_tick;
  logic wdog_wrap;

  // A kick in the wrap cycle wins over the wrap
  assign wdog_tick = st_r.wdog_en & (st_r.wtick == TICK_LAST);
  assign wdog_wrap = wdog_tick & (st_r.wdog == 8'hFF) & ~kick;

  // ****************************************************************
  // Divider routing
  // ****************************************************************
  logic cnt_inc;
  logic timeout;
  logic reassign;

  // Divider has a single input, chosen by the assign bit
  assign div_link.tick_in = assign_wdog ? wdog_wrap : src_tick;
  assign div_link.sel = sel;
  assign div_link.ce = ce;
  assign cnt_inc = assign_wdog ? src_tick : div_link.tick_out;
  assign timeout = assign_wdog ? div_link.tick_out : wdog_wrap;

  // Divider restarts on count write, reassign, timeout, or a kick while the divider is assigned to the watchdog
  assign reassign = wr_cfg & (pwdata[`RTWD_CFG_ASSIGN_BIT] != assign_wdog);
  assign div_link.clr = wr_count | reassign | (kick & assign_wdog) | timeout;

  // ****************************************************************
  // Read mux, divider count deliberately absent
  // ****************************************************************
  function automatic logic [31:0] read_word(
    input logic [7:0] addr,
    input rtwd_pkg::rtwd_state_t s
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (addr)
      `RTWD_OFS_CONFIG: w[7:0] = s.cfg;
      `RTWD_OFS_COUNT: w[7:0] = s.count;
      `RTWD_OFS_WDOG: w = {23'h000000, s.wdog, s.wdog_en};
      `RTWD_OFS_INT_STATUS: w[1:0] = s.int_status;
      `RTWD_OFS_INT_MASK: w[1:0] = s.int_mask;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Address in the register map
  function automatic logic addr_ok(input logic [7:0] addr);
    return (addr == `RTWD_OFS_CONFIG) || (addr == `RTWD_OFS_COUNT) ||
      (addr == `RTWD_OFS_WDOG) || (addr == `RTWD_OFS_INT_STATUS) ||
      (addr == `RTWD_OFS_INT_MASK);
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_nxt = st_r;

    // Pin synchroniser chain
    st_nxt.sync1 = ext_count_pin;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;

    // Bus answer: one wait-free access phase
    st_nxt.pready = setup_ph;
    if (setup_ph)
    begin
      st_nxt.prdata = read_word(paddr, st_r);
      st_nxt.pslverr = ~addr_ok(paddr);
    end
    else
    begin
      // Answer stands one cycle, then drops to zero
      st_nxt.prdata = 32'h0000_0000;
      st_nxt.pslverr = 1'b0;
    end

    // Free-running counter, a write wins over a count
    if (wr_count)
    begin
      st_nxt.count = pwdata[7:0];
    end
    else if (cnt_inc)
    begin
      st_nxt.count = st_r.count + 8'h01;
    end

    // Watchdog prescale tick
    if (!st_r.wdog_en || kick || wdog_tick)
    begin
      st_nxt.wtick = 16'h0000;
    end
    else
    begin
      st_nxt.wtick = st_r.wtick + 16'h0001;
    end

    // Watchdog counter
    if (kick || timeout)
    begin
      st_nxt.wdog = 8'h00;
    end
    else if (wdog_tick)
    begin
      st_nxt.wdog = st_r.wdog + 8'h01;
    end
    if (wr_wdog)
    begin
      st_nxt.wdog_en = pwdata[`RTWD_WDOG_EN_BIT];
    end

    // Configuration, reloaded by a watchdog timeout
    if (timeout)
    begin
      st_nxt.cfg = `RTWD_CFG_RESET;
    end
    else if (wr_cfg)
    begin
      st_nxt.cfg = pwdata[7:0];
    end

    // Interrupt mask
    if (wr_mask)
    begin
      st_nxt.int_mask = pwdata[1:0];
    end

    // Sticky status: read clears only bits returned, set wins
    if (rd_status)
    begin
      st_nxt.int_status = st_r.int_status & ~st_r.prdata[1:0];
    end
    if (cnt_inc && !wr_count && st_r.count == 8'hFF)
    begin
      st_nxt.int_status[`RTWD_INT_WRAP_BIT] = 1'b1;
    end
    if (timeout)
    begin
      st_nxt.int_status[`RTWD_INT_TMO_BIT] = 1'b1;
    end

    // Registered outputs
    st_nxt.irq = |(st_nxt.int_status & st_nxt.int_mask);
    st_nxt.wdog_rst = timeout;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
      st_r.cfg <= `RTWD_CFG_RESET;
      st_r.wdog_en <= `RTWD_WDOG_EN_RESET;
      st_r.int_status <= `RTWD_INT_RESET;
      st_r.int_mask <= `RTWD_INT_RESET;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pready = st_r.pready;
  assign prdata = st_r.prdata;
  assign pslverr = st_r.pslverr;
  assign irq = st_r.irq;
  assign wdog_reset_pulse = st_r.wdog_rst;

endmodule

/* verif/rtwd_asserts.sv */
module rtwd_asserts (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Pin and events
  input wire logic ext_count_pin,
  input wire logic irq,
  input wire logic wdog_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Bus and event checks
  // ********
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic setup;
  logic hit;
  logic rd_cyc;
  // Setup phase seen, address in the map, read answer cycle
  assign setup = psel && !penable && ce;
  assign hit = paddr[1:0] == 2'h0 && paddr <= 8'h10;
  assign rd_cyc = pready && !pwrite;
  ready_next_a: assert property (setup |=> pready)
    else $error("no ready after setup");
  ready_once_a: assert property (pready && ce |=> !pready)
    else $error("ready held too long");
  ready_cause_a: assert property ($rose(pready) |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  bad_addr_a: assert property (setup && !hit |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  idle_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  count_width_a: assert property (rd_cyc && paddr == 8'h04 |-> prdata[31:8] == 24'h0)
    else $error("counter wider than 8 bits");
  wdog_width_a: assert property (rd_cyc && paddr == 8'h08 |-> prdata[31:9] == 23'h0)
    else $error("watchdog wider than 8 bits");
  pulse_once_a: assert property (wdog_reset_pulse && ce |=> !wdog_reset_pulse)
    else $error("reset pulse too long");
  count_irq_a: assert property (rd_cyc && paddr == 8'h04 && irq && ce |=> irq)
    else $error("counter read cleared interrupt");
endmodule

bind rtwd_top rtwd_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .ext_count_pin(ext_count_pin), .irq(irq),
  .wdog_reset_pulse(wdog_reset_pulse)
);

/* verif/rtwd_pin_src.sv */
module rtwd_pin_src (
  // Clock
  input wire logic pclk,
  // Count pin
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // External count source, idles low
  // ********
  initial pin = 1'b0;
  // Toggle t times, each level held gap plus one cycles
  task automatic toggle(input int t, input int gap);
    repeat (t)
    begin
      @(posedge pclk);
      pin <= ~pin;
      repeat (gap) @(posedge pclk);
    end
  endtask
endmodule

/* verif/tb_rtwd_top.sv */
module tb_rtwd_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, irq, wpulse, pin, err;
  logic ce = 1'b1;
  int num_errors = 0, n_tests = 0, n_pulse = 0, v, n, t, k;
  // ********
  // Clock, design, count source
  // ********
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (wpulse === 1'b1) n_pulse <= n_pulse + 1;
  rtwd_top #(.WDOG_TICK_CYCLES(2)) uut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .ext_count_pin(pin),
    .irq(irq), .wdog_reset_pulse(wpulse));
  rtwd_pin_src u_pin (.pclk(pclk), .pin(pin));
  // ********
  // Tasks and expectations
  // ********
  task automatic finish_test;
    if (num_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, answer taken at the edge where pready is high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request held until the edge that samples pready high
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge before any next setup
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee = 1'b0);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
    chk(32'(err), 32'(ee));
  endtask
  // Cycles until the watchdog reset pulse
  task automatic wait_pulse(output int c);
    c = 0;
    do
    begin
      @(negedge pclk);
      c++;
    end
    while (wpulse !== 1'b1 && c < 3000);
    @(posedge pclk);
  endtask
  function automatic int f_edges(input int fall, input int tg);
    return fall ? tg / 2 : (tg + 1) / 2;
  endfunction
  function automatic int f_ratio(input int sel);
    return 1 << (sel + 1);
  endfunction
  // ********
  // Main sequence
  // ********
  initial
  begin
    v = $urandom(64652);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 32'hFF);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h0, 1'b1);
    // Undivided internal counting
    wr(8'h00, 32'h08);
    v = $urandom_range(200);
    n = $urandom_range(50, 20);
    wr(8'h04, v);
    // Frozen span must not count
    t = $urandom_range(20, 5);
    ce <= 1'b0;
    repeat (t) @(posedge pclk);
    ce <= 1'b1;
    repeat (n) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    k = rdat - v - n;
    chk(32'(k >= 1 && k <= 4), 32'h1);
    // Largest ratio ahead of the counter
    wr(8'h00, 32'h07);
    wr(8'h04, 32'h0);
    repeat (600) @(posedge pclk);
    rd(8'h04, 32'h2);
    // Wrap interrupt, unmasked then masked
    wr(8'h00, 32'h08);
    for (int m = 1; m >= 0; m--)
    begin
      wr(8'h10, m);
      wr(8'h04, 32'hF0);
      repeat (30) @(posedge pclk);
      apb(1'b0, 8'h04, 32'h0);
      chk(32'(irq), m);
      rd(8'h0C, 32'h1);
      rd(8'h0C, 32'h0);
      chk(32'(irq), 32'h0);
    end
    // Pin edges of either polarity
    for (int e = 0; e < 2; e++)
    begin
      wr(8'h00, 32'h28 | (e << 4));
      wr(8'h04, 32'h0);
      t = $urandom_range(9, 1);
      u_pin.toggle(t, $urandom_range(4, 1));
      repeat (6) @(posedge pclk);
      rd(8'h04, f_edges(e, t));
      u_pin.toggle(t % 2, 5);
    end
    // Every ratio ahead of the pin counter
    for (int s = 0; s < 8; s++)
    begin
      k = $urandom_range(2, 1);
      n = f_ratio(s) * k + $urandom_range(f_ratio(s) - 1);
      wr(8'h00, 32'h20 | s);
      wr(8'h04, 32'h0);
      u_pin.toggle(2 * n, 1);
      repeat (6) @(posedge pclk);
      rd(8'h04, k);
    end
    // Watchdog period without and with the divider
    wr(8'h00, 32'h20);
    wr(8'h08, 32'h1);
    wait_pulse(n);
    chk(32'(n >= 500 && n <= 530), 32'h1);
    rd(8'h00, 32'hFF);
    rd(8'h0C, 32'h2);
    wr(8'h00, 32'h29);
    wr(8'h08, 32'h3);
    wait_pulse(n);
    chk(32'(n >= 2040 && n <= 2070), 32'h1);
    // Kicks hold off the timeout
    wr(8'h00, 32'h20);
    wr(8'h08, 32'h3);
    k = n_pulse;
    repeat (3)
    begin
      repeat (400) @(posedge pclk);
      wr(8'h08, 32'h3);
    end
    chk(n_pulse, k);
    wr(8'h08, 32'h0);
    finish_test;
  end
  // Hang guard
  initial
  begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    finish_test;
  end
endmodule
